/* common/coc_pkg.sv */
// Constants, enumerations and carriers of the clock output control register bank.
// Assumes a 25 MHz core clock and an SMBus host on the serial pins.
package coc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [7:0] REG_HUNDRED_MHZ_ENABLE      = 8'h00;
  localparam logic [7:0] REG_MUX_OUT_ENABLE          = 8'h01;
  localparam logic [7:0] REG_LOW_FREQ_ENABLE_MUX_SEL = 8'h02;
  localparam logic [7:0] REG_RESERVED_THREE          = 8'h03;
  localparam logic [7:0] REG_RESERVED_FOUR           = 8'h04;
  localparam logic [7:0] REG_RESERVED_FIVE           = 8'h05;
  localparam logic [7:0] REG_SPREAD_SPECTRUM_CONTROL = 8'h06;
  localparam logic [7:0] REG_ENABLE_PIN_READBACK     = 8'h07;
  localparam logic [7:0] REG_VENDOR_REVISION_ID      = 8'h08;
  localparam logic [7:0] REG_DEVICE_ID               = 8'h09;
  localparam logic [7:0] REG_READ_BYTE_COUNT         = 8'h0A;
  localparam logic [7:0] REG_SIDEBAND_MASK_ZERO      = 8'h0B;
  localparam logic [7:0] REG_SIDEBAND_MASK_ONE       = 8'h0C;
  localparam logic [7:0] REG_SIDEBAND_MASK_TWO       = 8'h0D;
  localparam logic [7:0] REG_SIDEBAND_READBACK_ZERO  = 8'h0E;
  localparam logic [7:0] REG_SIDEBAND_READBACK_ONE   = 8'h0F;
  localparam logic [7:0] REG_SIDEBAND_READBACK_TWO   = 8'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_HUNDRED_MHZ_ENABLE = 8'h0B;
  localparam logic [7:0] RST_MUX_OUT_ENABLE     = 8'h30;
  localparam logic [7:0] RST_LOW_FREQ_MUX_SEL   = 8'hC4;
  localparam logic [7:0] RST_RESERVED_THREE     = 8'h00;
  localparam logic [3:0] RST_SPREAD_CONTROL     = 4'h0;
  localparam logic [5:0] RST_READ_BYTE_COUNT    = 6'h08;
  localparam logic [7:0] RST_SIDEBAND_MASK      = 8'h00;
  localparam logic [7:0] RST_SIDEBAND_RB_ZERO   = 8'hFF;
  localparam logic [7:0] RST_SIDEBAND_RB_ONE    = 8'hFF;
  localparam logic [7:0] RST_SIDEBAND_RB_TWO    = 8'h1E;

  // Writable bits per byte
  localparam logic [7:0] WMASK_LOW_FREQ_MUX_SEL = 8'hC7;
  localparam logic [7:0] WMASK_RESERVED_THREE   = 8'h7F;
  localparam logic [7:0] WMASK_SIDEBAND_TWO     = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int HM_BIT_0      = 0;
  localparam int HM_BIT_1      = 1;
  localparam int HM_BIT_3      = 3;
  localparam int MUX_BIT_4     = 4;
  localparam int MUX_BIT_5     = 5;
  localparam int MUX_MASK_4    = 5;
  localparam int MUX_MASK_5    = 6;
  localparam int LF_BIT_0      = 0;
  localparam int LF_BIT_1      = 1;
  localparam int LF_BIT_2      = 2;
  localparam int LF_RB_BIT_2   = 3;
  localparam int MUX_SEL_BIT   = 7;
  localparam int MUX_CTRL_BIT  = 6;
  localparam int SS_SRC_BIT    = 3;
  localparam int SS_SW_BIT     = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus addresses, write form, and the bit and settle count limits
  localparam logic [7:0] BUS_ADDR_LOW  = 8'hB2;
  localparam logic [7:0] BUS_ADDR_MID  = 8'hB4;
  localparam logic [7:0] BUS_ADDR_HIGH = 8'hB6;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
  localparam logic [1:0] SETTLE_DONE    = 2'h3;

  // Identification values, arbitrary
  localparam logic [3:0] ID_REVISION = 4'h5;
  localparam logic [3:0] ID_VENDOR   = 4'hA;
  localparam logic [7:0] ID_DEVICE   = 8'h3C;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } coc_bus_st_t;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [2:0] out_enable_pin_b;
    logic [1:0] spread_pin_level;
    logic       mux_freq_select;
    logic [1:0] address_select_pin;
    logic       power_good_pin;
    logic       side_band_load_strobe_b;
  } coc_pins_t;

  typedef struct packed {
    logic [7:0] image_two;
    logic [7:0] image_one;
    logic [7:0] image_zero;
  } coc_sbi_t;

  typedef struct packed {
    logic [2:0] hundred_mhz_on;
    logic [1:0] mux_out_on;
    logic [2:0] low_freq_on;
    logic       mux_at_25mhz;
    logic [1:0] spread_amount;
    logic       spread_from_filter;
  } coc_ctrl_t;

endpackage : coc_pkg

/* logic/coc_sync.sv */
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module coc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } coc_sync_state_t;

  coc_sync_state_t s;
  coc_sync_state_t next_s;

  always_comb begin
    next_s.first  = din;
    next_s.second = s.first;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.second;

endmodule : coc_sync

/* logic/coc_regs.sv */
// Byte-wide SMBus register bank steering the clock output enables and spread control.
// Assumes pins are asynchronous and the side-band image is stable when its load strobe falls.
//
// What this block does
// - Enable bits for 100 MHz outputs 3,1,0 and mux outputs 5,4; reset enabled.
// - Low-frequency enables in byte 2 bits 2..0; only output 2 resets enabled.
// - Byte 2 bit 6 picks pin or register mux frequency; bit 7 picks 25 MHz.
// - Byte 6 bits 5:4 show the live spread pin code.
// - Byte 6 bit 3 picks crystal or filter PLL as spread source; resets zero.
// - Byte 6 bit 2 picks pin or software spread amount; resets pin.
// - Byte 6 bits 1:0 hold the software spread code, loaded from pin after reset.
// - Byte 7 returns live enable pin levels 3,1,0; other bits zero.
// - Byte 8 returns fixed revision and vendor codes.
// - Byte 9 returns a fixed device code.
// - Byte 10 bits 5:0 hold block read count, reset eight; upper bits zero.
// - Side-band mask bits in bytes 11 to 13, reset zero.
// - A set mask forces the side-band path to report enabled.
// - A masked output can still be turned off by SMBus bit or enable pin.
// - Bytes 14 to 16 return the latched side-band image.
// - Side-band readback resets to FF, FF and 1E.
// - Outputs other than low-frequency 0 and 1 run only when SMBus bit and side-band path allow it; 100 MHz outputs also need their pin.
// - Byte 3 reserved with bit 7 read-only; bytes 4 and 5 read-only.
// - Write: address, index, count, data bytes, each acknowledged, index increments.
// - Read: index, repeated start, count byte then data until host refuses.
// - Side-band readback updates on each falling edge of the load strobe.
// - Tri-level address pin selects B2, B4 or B6.
`timescale 1ns/1ps
module coc_regs
  import coc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire coc_pins_t pins_raw,
  input  wire coc_sbi_t  side_band_image,
  output logic           sda_out,
  output logic           sda_oe,
  output coc_ctrl_t      ctrl
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    coc_bus_st_t st;
    coc_bus_st_t ack_next;
    logic [7:0]  sh;
    logic [3:0]  cnt;
    logic [7:0]  idx;
    logic        nack;
    logic        scl_q;
    logic        sda_q;
    logic        load_q;
    logic        sda_out;
    logic        sda_oe;
    logic [7:0]  hm_en;
    logic [7:0]  mux_en;
    logic [7:0]  lf_sel;
    logic [7:0]  rsv3;
    logic [3:0]  ss_ctl;
    logic [5:0]  byte_cnt;
    logic [7:0]  mask0;
    logic [7:0]  mask1;
    logic [7:0]  mask2;
    logic [7:0]  sbr0;
    logic [7:0]  sbr1;
    logic [7:0]  sbr2;
    logic [1:0]  settle;
    logic        ss_cap;
    coc_ctrl_t   ctrl;
  } coc_regs_state_t;

  coc_regs_state_t s;
  coc_regs_state_t next_s;
  coc_pins_t       p;

  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;
  logic [7:0]      rd_byte;

  coc_sync #(
    .W ($bits(coc_pins_t))
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (pins_raw),
    .dout  (p)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Tri-level code: 00 low, 01 middle, 1x high
  function automatic logic [6:0] bus_addr(input logic [1:0] code);
    logic [7:0] a;
    a = (code == 2'h0) ? BUS_ADDR_LOW : (code == 2'h1) ? BUS_ADDR_MID : BUS_ADDR_HIGH;
    return a[7:1];
  endfunction : bus_addr

  // SMBus bit, side-band path and pin must all allow the output
  function automatic logic out_on(input logic smb, input logic sb, input logic mask, input logic pin_ok);
    return smb & (sb | mask) & pin_ok;
  endfunction : out_on

  function automatic logic [7:0] read_reg(input coc_regs_state_t r, input coc_pins_t q, input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      REG_HUNDRED_MHZ_ENABLE:      v = r.hm_en;
      REG_MUX_OUT_ENABLE:          v = r.mux_en;
      REG_LOW_FREQ_ENABLE_MUX_SEL: v = r.lf_sel;
      REG_RESERVED_THREE:          v = r.rsv3;
      REG_SPREAD_SPECTRUM_CONTROL: v = {2'h0, q.spread_pin_level, r.ss_ctl};
      REG_ENABLE_PIN_READBACK:     v = {4'h0, q.out_enable_pin_b[2], 1'b0, q.out_enable_pin_b[1:0]};
      REG_VENDOR_REVISION_ID:      v = {ID_REVISION, ID_VENDOR};
      REG_DEVICE_ID:               v = ID_DEVICE;
      REG_READ_BYTE_COUNT:         v = {2'h0, r.byte_cnt};
      REG_SIDEBAND_MASK_ZERO:      v = q.power_good_pin ? r.mask0 : 8'h00;
      REG_SIDEBAND_MASK_ONE:       v = q.power_good_pin ? r.mask1 : 8'h00;
      REG_SIDEBAND_MASK_TWO:       v = q.power_good_pin ? r.mask2 : 8'h00;
      REG_SIDEBAND_READBACK_ZERO:  v = r.sbr0;
      REG_SIDEBAND_READBACK_ONE:   v = r.sbr1;
      REG_SIDEBAND_READBACK_TWO:   v = r.sbr2;
      default:                     v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  ////////////////////////////////////////////////////////////////////////////////
  // Bus conditions

  assign scl_rise   = p.scl & ~s.scl_q;
  assign scl_fall   = ~p.scl & s.scl_q;
  assign start_seen = p.scl & s.scl_q & s.sda_q & ~p.sda;
  assign stop_seen  = p.scl & s.scl_q & ~s.sda_q & p.sda;
  assign rd_byte    = read_reg(s, p, s.idx);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s         = s;
    next_s.scl_q   = p.scl;
    next_s.sda_q   = p.sda;
    next_s.load_q  = p.side_band_load_strobe_b;
    next_s.sda_out = 1'b0;

    // Spread code caught from the pin once synchronisers have settled
    if (s.settle != SETTLE_DONE) begin
      next_s.settle = s.settle + 2'h1;
    end else if (!s.ss_cap) begin
      next_s.ss_cap      = 1'b1;
      next_s.ss_ctl[1:0] = p.spread_pin_level;
    end

    // Side-band image latched on the strobe falling edge
    if (s.load_q && !p.side_band_load_strobe_b) begin
      next_s.sbr0 = side_band_image.image_zero;
      next_s.sbr1 = side_band_image.image_one;
      next_s.sbr2 = side_band_image.image_two;
    end

    if (start_seen) begin
      next_s.st     = ST_ADDR;
      next_s.cnt    = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_s.st     = ST_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (s.st == ST_ADDR || s.st == ST_INDEX || s.st == ST_COUNT || s.st == ST_WDATA) begin
        next_s.sh  = {s.sh[6:0], p.sda};
        next_s.cnt = s.cnt + 4'h1;
      end else if (s.st == ST_RDATA) begin
        next_s.cnt = s.cnt + 4'h1;
      end else if (s.st == ST_RACK) begin
        next_s.nack = p.sda;
      end
    end else if (scl_fall) begin
      unique case (s.st)
        ST_ADDR: begin
          if (s.cnt == BIT_COUNT_BYTE) begin
            if (s.sh[7:1] == bus_addr(p.address_select_pin)) begin
              next_s.sda_oe   = 1'b1;
              next_s.st       = ST_ACK;
              next_s.ack_next = s.sh[0] ? ST_RDATA : ST_INDEX;
            end else begin
              next_s.st = ST_IGNORE;
            end
          end
        end
        ST_INDEX: begin
          if (s.cnt == BIT_COUNT_BYTE) begin
            next_s.idx      = s.sh;
            next_s.sda_oe   = 1'b1;
            next_s.st       = ST_ACK;
            next_s.ack_next = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (s.cnt == BIT_COUNT_BYTE) begin
            next_s.sda_oe   = 1'b1;
            next_s.st       = ST_ACK;
            next_s.ack_next = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (s.cnt == BIT_COUNT_BYTE) begin
            next_s.sda_oe   = 1'b1;
            next_s.st       = ST_ACK;
            next_s.ack_next = ST_WDATA;
            next_s.idx      = s.idx + 8'h01;
            unique case (s.idx)
              REG_HUNDRED_MHZ_ENABLE:      next_s.hm_en    = s.sh;
              REG_MUX_OUT_ENABLE:          next_s.mux_en   = s.sh;
              REG_LOW_FREQ_ENABLE_MUX_SEL: next_s.lf_sel   = s.sh & WMASK_LOW_FREQ_MUX_SEL;
              REG_RESERVED_THREE:          next_s.rsv3     = s.sh & WMASK_RESERVED_THREE;
              REG_SPREAD_SPECTRUM_CONTROL: next_s.ss_ctl   = s.sh[3:0];
              REG_READ_BYTE_COUNT:         next_s.byte_cnt = s.sh[5:0];
              REG_SIDEBAND_MASK_ZERO: begin
                if (p.power_good_pin) begin
                  next_s.mask0 = s.sh;
                end
              end
              REG_SIDEBAND_MASK_ONE: begin
                if (p.power_good_pin) begin
                  next_s.mask1 = s.sh;
                end
              end
              REG_SIDEBAND_MASK_TWO: begin
                if (p.power_good_pin) begin
                  next_s.mask2 = s.sh & WMASK_SIDEBAND_TWO;
                end
              end
              default: ;
            endcase
          end
        end
        ST_ACK: begin
          next_s.cnt = 4'h0;
          next_s.st  = s.ack_next;
          if (s.ack_next == ST_RDATA) begin
            next_s.sh     = {2'h0, s.byte_cnt};
            next_s.sda_oe = ~s.byte_cnt[5] & 1'b0 | 1'b1; // Count msb is always zero
          end else begin
            next_s.sda_oe = 1'b0;
          end
        end
        ST_RDATA: begin
          if (s.cnt == BIT_COUNT_BYTE) begin
            next_s.sda_oe = 1'b0;
            next_s.st     = ST_RACK;
          end else begin
            next_s.sh     = {s.sh[6:0], 1'b0};
            next_s.sda_oe = ~s.sh[6];
          end
        end
        ST_RACK: begin
          if (!s.nack) begin
            next_s.sh     = rd_byte;
            next_s.idx    = s.idx + 8'h01;
            next_s.sda_oe = ~rd_byte[7];
            next_s.cnt    = 4'h0;
            next_s.st     = ST_RDATA;
          end else begin
            next_s.st = ST_IGNORE;
          end
        end
        ST_IDLE, ST_IGNORE: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output enables and clock settings

    next_s.ctrl.hundred_mhz_on[0] = out_on(s.hm_en[HM_BIT_0], s.sbr0[HM_BIT_0], s.mask0[HM_BIT_0],
                                           ~p.out_enable_pin_b[0]);
    next_s.ctrl.hundred_mhz_on[1] = out_on(s.hm_en[HM_BIT_1], s.sbr0[HM_BIT_1], s.mask0[HM_BIT_1],
                                           ~p.out_enable_pin_b[1]);
    next_s.ctrl.hundred_mhz_on[2] = out_on(s.hm_en[HM_BIT_3], s.sbr0[HM_BIT_3], s.mask0[HM_BIT_3],
                                           ~p.out_enable_pin_b[2]);
    next_s.ctrl.mux_out_on[0]     = out_on(s.mux_en[MUX_BIT_4], s.sbr1[MUX_BIT_4], s.mask1[MUX_MASK_4],
                                           1'b1);
    next_s.ctrl.mux_out_on[1]     = out_on(s.mux_en[MUX_BIT_5], s.sbr1[MUX_BIT_5], s.mask1[MUX_MASK_5],
                                           1'b1);
    next_s.ctrl.low_freq_on[0]    = s.lf_sel[LF_BIT_0];
    next_s.ctrl.low_freq_on[1]    = s.lf_sel[LF_BIT_1];
    next_s.ctrl.low_freq_on[2]    = out_on(s.lf_sel[LF_BIT_2], s.sbr2[LF_RB_BIT_2], s.mask2[LF_BIT_2],
                                           1'b1);
    next_s.ctrl.mux_at_25mhz      = s.lf_sel[MUX_CTRL_BIT] ? s.lf_sel[MUX_SEL_BIT] : p.mux_freq_select;
    next_s.ctrl.spread_amount     = s.ss_ctl[SS_SW_BIT] ? s.ss_ctl[1:0] : p.spread_pin_level;
    next_s.ctrl.spread_from_filter = s.ss_ctl[SS_SRC_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.ack_next <= ST_IDLE;
      s.scl_q    <= 1'b1;
      s.sda_q    <= 1'b1;
      s.load_q   <= 1'b0; // Synchroniser resets low, so no false load edge
      s.hm_en    <= RST_HUNDRED_MHZ_ENABLE;
      s.mux_en   <= RST_MUX_OUT_ENABLE;
      s.lf_sel   <= RST_LOW_FREQ_MUX_SEL;
      s.rsv3     <= RST_RESERVED_THREE;
      s.ss_ctl   <= RST_SPREAD_CONTROL;
      s.byte_cnt <= RST_READ_BYTE_COUNT;
      s.mask0    <= RST_SIDEBAND_MASK;
      s.mask1    <= RST_SIDEBAND_MASK;
      s.mask2    <= RST_SIDEBAND_MASK;
      s.sbr0     <= RST_SIDEBAND_RB_ZERO;
      s.sbr1     <= RST_SIDEBAND_RB_ONE;
      s.sbr2     <= RST_SIDEBAND_RB_TWO;
    end else begin
      s <= next_s;
    end
  end

  assign sda_out = s.sda_out;
  assign sda_oe  = s.sda_oe;
  assign ctrl    = s.ctrl;

endmodule : coc_regs

/* tb/coc_regs_asserts.sv */
// Checker on the register bank ports: serial answer timing and pin-driven enables.
// Assumes a host that keeps each scl phase at least 4 clocks long.
`timescale 1ns/1ps
module coc_regs_asserts
  import coc_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst_b,
  input wire coc_pins_t pins_raw,
  input wire coc_sbi_t  side_band_image,
  input wire logic      sda_out,
  input wire logic      sda_oe,
  input wire coc_ctrl_t ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_drive_start; $rose(sda_oe); endsequence
  sequence s_pin_high(b); b [*6]; endsequence

  a_drive_low: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  a_ack_holds: assert property (s_drive_start |-> sda_oe [*6]) else $error("sda pulse too short");
  a_turn_scl_low: assert property ($changed(sda_oe) |-> !$past(pins_raw.scl, 2))
    else $error("sda moved while scl high");
  a_quiet_start: assert property ($rose(rst_b) |-> !sda_oe [*4]) else $error("sda driven after reset");
  a_reset_ctrl_zero: assert property ($rose(rst_b) |-> ctrl == '0) else $error("ctrl not cleared");
  a_pin_off_zero: assert property (s_pin_high(pins_raw.out_enable_pin_b[0]) |-> !ctrl.hundred_mhz_on[0])
    else $error("output 0 on with pin high");
  a_pin_off_one: assert property (s_pin_high(pins_raw.out_enable_pin_b[1]) |-> !ctrl.hundred_mhz_on[1])
    else $error("output 1 on with pin high");
  a_pin_off_three: assert property (s_pin_high(pins_raw.out_enable_pin_b[2]) |-> !ctrl.hundred_mhz_on[2])
    else $error("output 3 on with pin high");
endmodule : coc_regs_asserts

bind coc_regs coc_regs_asserts u_coc_regs_asserts (.clk(clk), .rst_b(rst_b), .pins_raw(pins_raw),
  .side_band_image(side_band_image), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl));

/* tb/coc_smb_host.sv */
// Behavioural SMBus host: open-drain data, scl phases of 8 clocks.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module coc_smb_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hp;
    repeat (8) @(negedge clk);
  endtask : hp

  // Start and repeated start alike
  task automatic start;
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask : stop

  // One bit out, line level sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hp();
    scl = 1'b1;
    repeat (4) @(negedge clk);
    r = sda;
    repeat (4) @(negedge clk);
    scl = 1'b0;
  endtask : bit_io

  // Eight bits MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, r);
  endtask : xfer
endmodule : coc_smb_host

/* tb/coc_regs_tb.sv */
// Self-checking bench for the register bank driven through the SMBus host model.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module coc_regs_tb
  import coc_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  coc_pins_t  pv = 12'h063;
  coc_sbi_t   side_band_path = '1;
  logic       scl, host_low, sda_out, sda_oe, sda_w;
  coc_pins_t  pins;
  coc_ctrl_t  ctrl;
  logic [7:0] rcnt;
  int         err_total = 0;
  int         n_checks = 0;
  int         cycles = 0;

  assign sda_w = !(host_low || (sda_oe && !sda_out));
  assign pins = {scl, sda_w, pv[9:0]};
  always #20 clk = ~clk;
  coc_regs uut (.clk(clk), .rst_b(rst_b), .pins_raw(pins), .side_band_image(side_band_path), .sda_out(sda_out),
    .sda_oe(sda_oe), .ctrl(ctrl));
  coc_smb_host host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(host_low));

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    logic [7:0] b[$];
    logic [7:0] q;
    logic       r;
    b = {BUS_ADDR_LOW, idx, 8'(d.size()), d};
    host.start();
    foreach (b[i]) begin
      host.xfer(b[i], 1'b1, q, r);
      chk("ack", 16'h0, 16'(r));
    end
    host.stop();
    repeat (8) @(negedge clk);
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e[$]);
    logic [7:0] q;
    logic       r;
    host.start();
    host.xfer(BUS_ADDR_LOW, 1'b1, q, r);
    host.xfer(idx, 1'b1, q, r);
    host.start();
    host.xfer(BUS_ADDR_LOW | 8'h01, 1'b1, q, r);
    chk("read ack", 16'h0, 16'(r));
    host.xfer(8'hFF, 1'b0, rcnt, r);
    foreach (e[i]) begin
      host.xfer(8'hFF, 1'(i == e.size() - 1), q, r);
      chk($sformatf("byte %0d", idx + i), 16'(e[i]), 16'(q));
    end
    host.stop();
  endtask : rchk

  task automatic conclude;
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(8'h00, {8'h0B, 8'h30, 8'hC4, 8'h00, 8'h00, 8'h00, 8'h33, 8'h00});
    rchk(8'h08, {8'({ID_REVISION, ID_VENDOR}), ID_DEVICE, 8'h08, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h1E});
    chk("count", 16'h08, 16'(rcnt));
    chk("ctrl", 16'h0FCE, 16'(ctrl));
  endtask : t_reset

  task automatic t_write;
    wr(8'h00, {8'h00});
    chk("h100", 16'h0, 16'(ctrl.hundred_mhz_on));
    wr(8'h01, {8'h00, 8'h3B, 8'hFF});
    pv.mux_freq_select = 1'b1;
    repeat (8) @(negedge clk);
    rchk(8'h01, {8'h00, 8'h03, 8'h7F});
    chk("mux lf m25", 16'h007, 16'({ctrl.mux_out_on, ctrl.low_freq_on, ctrl.mux_at_25mhz}));
    pv.mux_freq_select = 1'b0;
    repeat (8) @(negedge clk);
    chk("m25", 16'h0, 16'(ctrl.mux_at_25mhz));
    wr(8'h0A, {8'hFF});
    rchk(8'h0A, {8'h3F});
    chk("count", 16'h3F, 16'(rcnt));
    wr(8'h00, {8'h0B, 8'h30, 8'hC4, 8'h00});
    wr(8'h07, {8'hFF, 8'h00, 8'h00});
    wr(8'h0E, {8'h00, 8'h00, 8'h00});
    rchk(8'h07, {8'h00, 8'({ID_REVISION, ID_VENDOR}), ID_DEVICE});
    rchk(8'h0E, {8'hFF, 8'hFF, 8'h1E});
  endtask : t_write

  task automatic t_pins;
    wr(8'h06, {8'hCD});
    rchk(8'h06, {8'h3D});
    chk("spread", 16'h3, 16'({ctrl.spread_amount, ctrl.spread_from_filter}));
    pv.spread_pin_level = 2'h1;
    pv.out_enable_pin_b = 3'b101;
    repeat (8) @(negedge clk);
    rchk(8'h06, {8'h1D, 8'h09});
    chk("h100", 16'h2, 16'(ctrl.hundred_mhz_on));
    wr(8'h06, {8'h00});
    chk("spread", 16'h2, 16'({ctrl.spread_amount, ctrl.spread_from_filter}));
    pv.out_enable_pin_b = 3'b000;
  endtask : t_pins

  task automatic t_side;
    side_band_path = '0;
    pv.side_band_load_strobe_b = 1'b0;
    repeat (8) @(negedge clk);
    pv.side_band_load_strobe_b = 1'b1;
    rchk(8'h0E, {8'h00, 8'h00, 8'h00});
    chk("on", 16'h0, 16'({ctrl.hundred_mhz_on, ctrl.mux_out_on, ctrl.low_freq_on}));
    wr(8'h0B, {8'h0B, 8'h60, 8'hFC});
    rchk(8'h0B, {8'h0B, 8'h60, 8'h0C});
    chk("on", 16'hFC, 16'({ctrl.hundred_mhz_on, ctrl.mux_out_on, ctrl.low_freq_on}));
    wr(8'h00, {8'h0A});
    chk("h100", 16'h6, 16'(ctrl.hundred_mhz_on));
    pv.power_good_pin = 1'b0;
    wr(8'h0B, {8'h00});
    rchk(8'h0B, {8'h00});
    pv.power_good_pin = 1'b1;
    rchk(8'h0B, {8'h0B});
  endtask : t_side

  task automatic t_addr;
    logic [7:0] m[3] = '{BUS_ADDR_LOW, BUS_ADDR_MID, BUS_ADDR_HIGH};
    logic [7:0] q;
    logic       r;
    for (int p = 0; p < 3; p++) begin
      pv.address_select_pin = 2'(p);
      repeat (8) @(negedge clk);
      for (int k = 0; k < 3; k++) begin
        host.start();
        host.xfer(m[k], 1'b1, q, r);
        host.stop();
        chk($sformatf("addr %h", m[k]), 16'(p != k), 16'(r));
      end
    end
  endtask : t_addr

  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    t_write();
    t_pins();
    t_side();
    t_addr();
    conclude();
  end
endmodule : coc_regs_tb
